// ---- bench/lsr_host.sv ----
// Purpose: two-wire bus host that drives the light sensor link
// Assumes: data wire has a pull-up; link clock stands high between frames
// Notes:   12 ns bit period; data moves 1 ns after the clock falls
`timescale 1ns/1ps

module lsr_host (
	// link clock and host data drive
	output logic      scl,
	output logic      sda_drv,
	// resolved data wire
	input  wire logic sda_in
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// one bit: hold data across the rising edge so no false start or stop
	task automatic bit_x(input logic b, output logic r);
		scl = 1'b0;
		#1 sda_drv = b;
		#5 scl = 1'b1;
		r = sda_in;
		#6;
	endtask

	// start, also used as repeated start
	task automatic start_c;
		scl = 1'b0;
		#1 sda_drv = 1'b1;
		#5 scl = 1'b1;
		#3 sda_drv = 1'b0;
		#3;
	endtask

	// stop then bus free time
	task automatic stop_c;
		scl = 1'b0;
		#1 sda_drv = 1'b0;
		#5 scl = 1'b1;
		#3 sda_drv = 1'b1;
		#40;
	endtask

	// byte out, ok cleared when the device does not pull the ack low
	task automatic put_byte(input logic [7:0] d, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ok = ok & ~r;
	endtask

	// byte in with data released, then host ack or nack
	task automatic get_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(~ack, r);
	endtask

	// register write: lower byte first, then upper byte
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w, output logic ok);
		ok = 1'b1;
		start_c();
		put_byte({a, 1'b0}, ok);
		put_byte(c, ok);
		put_byte(w[7:0], ok);
		put_byte(w[15:8], ok);
		stop_c();
	endtask

	// register read through repeated start, nack on the upper byte ends it
	task automatic rd_reg(input logic [6:0] a, input logic [7:0] c, output logic [15:0] w, output logic ok);
		ok = 1'b1;
		start_c();
		put_byte({a, 1'b0}, ok);
		put_byte(c, ok);
		start_c();
		put_byte({a, 1'b1}, ok);
		get_byte(1'b1, w[7:0]);
		get_byte(1'b0, w[15:8]);
		stop_c();
	endtask
endmodule

// ---- bench/lsr_top_bench.sv ----
// Purpose: self-checking bench for the light sensor register bank
// Assumes: host model owns the link clock; core inputs move 1 ns after CLK
// Notes:   one ms shortened to 10 cycles so pacing fits the run
`timescale 1ns/1ps

module lsr_top_bench;
	localparam int MS = 10;
	localparam logic [12:0] BASE [4] = '{13'h0258, 13'h02BC, 13'h0384, 13'h0514};
	localparam logic [12:0] EXTRA [4] = '{13'h0000, 13'h01F4, 13'h05DC, 13'h0DAC};

	logic        clk;
	logic        reset_n;
	logic        addr_sel;
	logic        alert_enable;
	logic [15:0] high_bound;
	logic [3:0]  it_code;
	logic        meas_valid;
	logic [15:0] meas_ambient;
	logic [15:0] meas_white;
	wire logic   scl;
	wire logic   host_sda;
	wire logic   sda_oe;
	wire logic   sda_out;
	wire logic   sda_wire;
	wire logic [15:0] low_bound;
	wire logic        ps_en;
	wire logic [1:0]  ps_sel;
	wire logic [12:0] refresh_ms;
	wire logic        meas_start;
	wire logic        low_flag;
	wire logic        high_flag;
	int          err_total;
	int          samples_checked;
	int          cyc;
	int          n;
	logic [15:0] rd;
	logic        ok;

	// open-drain wire with pull-up
	assign sda_wire = host_sda & ~(sda_oe & ~sda_out);

	lsr_top #(.MS_CYCLES(MS)) lsr_top_inst (
		.CLK(clk), .RESET_N(reset_n), .SCL(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.ADDR_SEL(addr_sel), .ALERT_ENABLE(alert_enable), .HIGH_BOUND(high_bound),
		.INTEGRATION_TIME_CODE(it_code), .MEAS_VALID(meas_valid), .MEAS_AMBIENT(meas_ambient),
		.MEAS_WHITE(meas_white), .LOW_BOUND(low_bound), .POWER_SAVE_ENABLE(ps_en),
		.POWER_SAVE_SELECT(ps_sel), .REFRESH_MS(refresh_ms), .MEAS_START(meas_start),
		.LOW_CROSSING_FLAG(low_flag), .HIGH_CROSSING_FLAG(high_flag)
	);
	lsr_host lsr_host_inst (.scl(scl), .sda_drv(host_sda), .sda_in(sda_wire));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// hang guard: the run needs about 15k cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// one converter result, then let the flag update land
	task automatic meas(input logic [15:0] a, input logic [15:0] w);
		tick(1);
		meas_ambient = a;
		meas_white = w;
		meas_valid = 1'b1;
		tick(1);
		meas_valid = 1'b0;
		tick(2);
	endtask

	// cycles until the next start pulse, bounded
	task automatic wait_start(output int k);
		k = 0;
		do begin
			tick(1);
			k++;
		end while (meas_start !== 1'b1 && k < 8000);
	endtask

	initial begin
		{reset_n, alert_enable, meas_valid, it_code, meas_ambient, meas_white} = '0;
		{addr_sel, high_bound} = {1'b1, 16'h8000};
		{err_total, samples_checked, cyc} = '0;
		repeat (3) @(posedge clk);
		#1 reset_n = 1'b1;
		tick(3);
		chk("refresh rst", 16'h0258, {3'h0, refresh_ms});
		lsr_host_inst.wr_reg(7'h48, 8'h02, 16'hABCD, ok);
		tick(4);
		chk("ack", 16'h0001, {15'h0, ok});
		chk("sda out", 16'h0000, {15'h0, sda_out});
		chk("low_bound", 16'hABCD, low_bound);
		lsr_host_inst.rd_reg(7'h48, 8'h02, rd, ok);
		chk("low rd", 16'h0000, rd);
		lsr_host_inst.wr_reg(7'h10, 8'h02, 16'h1234, ok);
		tick(4);
		chk("foreign ack", 16'h0000, {15'h0, ok});
		chk("low kept", 16'hABCD, low_bound);
		addr_sel = 1'b0;
		lsr_host_inst.wr_reg(7'h10, 8'h02, 16'h1234, ok);
		tick(4);
		chk("low strap", 16'h1234, low_bound);
		addr_sel = 1'b1;
		$display("test threshold and address done");
		for (int m = 0; m < 4; m++) begin
			lsr_host_inst.wr_reg(7'h48, 8'h03, {13'h0000, 2'(m), 1'b1}, ok);
			tick(4);
			chk("mode", 16'(m * 2 + 1), {13'h0, ps_sel, ps_en});
			for (int i = 0; i < 4; i++) begin
				it_code = 4'(i);
				tick(3);
				chk("refresh", 16'(BASE[i] + EXTRA[m]), {3'h0, refresh_ms});
			end
		end
		it_code = 4'hC;
		tick(3);
		chk("refresh other", 16'(BASE[0] + EXTRA[3]), {3'h0, refresh_ms});
		it_code = 4'h0;
		lsr_host_inst.wr_reg(7'h48, 8'h03, 16'h0000, ok);
		tick(4);
		chk("ps off", 16'h0000, {13'h0, ps_sel, ps_en});
		lsr_host_inst.wr_reg(7'h48, 8'h03, 16'h0001, ok);
		wait_start(n);
		wait_start(n);
		chk("start gap", 16'(BASE[0] * MS), 16'(n));
		lsr_host_inst.wr_reg(7'h48, 8'h03, 16'h0000, ok);
		$display("test power saving done");
		meas(16'h1357, 16'h2468);
		meas(16'h0001, 16'h2468);
		chk("alert off", 16'h0000, {14'h0, low_flag, high_flag});
		lsr_host_inst.rd_reg(7'h48, 8'h04, rd, ok);
		chk("ambient", 16'h0001, rd);
		lsr_host_inst.rd_reg(7'h48, 8'h05, rd, ok);
		chk("white", 16'h2468, rd);
		meas(16'hC3A5, 16'h5A3C);
		lsr_host_inst.rd_reg(7'h48, 8'h04, rd, ok);
		chk("ambient", 16'hC3A5, rd);
		lsr_host_inst.rd_reg(7'h48, 8'h05, rd, ok);
		chk("white", 16'h5A3C, rd);
		$display("test results done");
		alert_enable = 1'b1;
		meas(16'h1234, 16'h0000);
		meas(16'h8000, 16'h0000);
		chk("on bounds", 16'h0000, {14'h0, low_flag, high_flag});
		meas(16'h1233, 16'h0000);
		chk("low flag", 16'h0002, {14'h0, low_flag, high_flag});
		lsr_host_inst.rd_reg(7'h48, 8'h06, rd, ok);
		chk("status low", 16'h8000, rd);
		tick(6);
		chk("cleared", 16'h0000, {14'h0, low_flag, high_flag});
		meas(16'h8001, 16'h0000);
		lsr_host_inst.wr_reg(7'h48, 8'h06, 16'h0000, ok);
		tick(6);
		chk("high held", 16'h0001, {14'h0, low_flag, high_flag});
		lsr_host_inst.rd_reg(7'h48, 8'h06, rd, ok);
		chk("status high", 16'h4000, rd);
		lsr_host_inst.rd_reg(7'h48, 8'h06, rd, ok);
		chk("status empty", 16'h0000, rd);
		$display("test flags done");
		tally_and_finish();
	end
endmodule

// ---- bench/lsr_top_checker.sv ----
// Purpose: concurrent checks on the core side of the register bank
// Assumes: one CLK domain; link pins are judged by the bench
// Notes:   pacing check skips the first pulse after any setting change
`timescale 1ns/1ps

module lsr_top_checker #(
	parameter int MS_CYCLES = 10
) (
	// clock and reset
	input wire logic        CLK,
	input wire logic        RESET_N,
	// converter side
	input wire logic        ALERT_ENABLE,
	input wire logic [15:0] HIGH_BOUND,
	input wire logic [3:0]  INTEGRATION_TIME_CODE,
	input wire logic        MEAS_VALID,
	input wire logic [15:0] MEAS_AMBIENT,
	// register outputs
	input wire logic [15:0] LOW_BOUND,
	input wire logic        POWER_SAVE_ENABLE,
	input wire logic [1:0]  POWER_SAVE_SELECT,
	input wire logic [12:0] REFRESH_MS,
	input wire logic        MEAS_START,
	input wire logic        LOW_CROSSING_FLAG,
	input wire logic        HIGH_CROSSING_FLAG
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	logic [31:0] gap_cnt;
	logic        armed;

	// interval table: base by integration code plus extra by mode
	function automatic logic [12:0] refresh_of(logic [1:0] m, logic [3:0] it);
		logic [12:0] b;
		b = (it == 4'h1) ? 13'h02BC : (it == 4'h2) ? 13'h0384 : (it == 4'h3) ? 13'h0514 : 13'h0258;
		return b + ((m == 2'h1) ? 13'h01F4 : (m == 2'h2) ? 13'h05DC : (m == 2'h3) ? 13'h0DAC : 13'h0000);
	endfunction

	// cycles since last start; disarmed when settings move so a restart is not misjudged
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			gap_cnt <= 32'h0;
			armed <= 1'b0;
		end else begin
			gap_cnt <= MEAS_START ? 32'h1 : gap_cnt + 32'h1;
			armed <= POWER_SAVE_ENABLE && !$changed(REFRESH_MS) && (MEAS_START || armed);
		end
	end

	sequence s_low_cause;
		MEAS_VALID && ALERT_ENABLE && (MEAS_AMBIENT < LOW_BOUND);
	endsequence
	sequence s_high_cause;
		MEAS_VALID && ALERT_ENABLE && (MEAS_AMBIENT > HIGH_BOUND);
	endsequence

	property p_low_set;
		s_low_cause |=> LOW_CROSSING_FLAG;
	endproperty
	property p_high_set;
		s_high_cause |=> HIGH_CROSSING_FLAG;
	endproperty
	property p_quiet;
		!ALERT_ENABLE && !LOW_CROSSING_FLAG && !HIGH_CROSSING_FLAG |=> !LOW_CROSSING_FLAG && !HIGH_CROSSING_FLAG;
	endproperty
	property p_rise_cause;
		$rose(LOW_CROSSING_FLAG) || $rose(HIGH_CROSSING_FLAG) |-> $past(MEAS_VALID) && $past(ALERT_ENABLE);
	endproperty
	property p_start_off;
		!POWER_SAVE_ENABLE [*2] |-> !MEAS_START;
	endproperty
	property p_pulse;
		MEAS_START |=> !MEAS_START;
	endproperty
	property p_refresh;
		REFRESH_MS == refresh_of($past(POWER_SAVE_SELECT), $past(INTEGRATION_TIME_CODE));
	endproperty
	property p_pace;
		MEAS_START && armed |-> gap_cnt == REFRESH_MS * MS_CYCLES;
	endproperty

	a_low_set: assert property (p_low_set) else $error("low flag missing");
	a_high_set: assert property (p_high_set) else $error("high flag missing");
	a_quiet: assert property (p_quiet) else $error("flag set while alert off");
	a_rise_cause: assert property (p_rise_cause) else $error("flag rose without result");
	a_start_off: assert property (p_start_off) else $error("start while disabled");
	a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
	a_refresh: assert property (p_refresh) else $error("refresh interval wrong");
	a_pace: assert property (p_pace) else $error("start spacing wrong");
endmodule

bind lsr_top lsr_top_checker #(.MS_CYCLES(MS_CYCLES)) lsr_top_checker_inst (
	.CLK(CLK),
	.RESET_N(RESET_N),
	.ALERT_ENABLE(ALERT_ENABLE),
	.HIGH_BOUND(HIGH_BOUND),
	.INTEGRATION_TIME_CODE(INTEGRATION_TIME_CODE),
	.MEAS_VALID(MEAS_VALID),
	.MEAS_AMBIENT(MEAS_AMBIENT),
	.LOW_BOUND(LOW_BOUND),
	.POWER_SAVE_ENABLE(POWER_SAVE_ENABLE),
	.POWER_SAVE_SELECT(POWER_SAVE_SELECT),
	.REFRESH_MS(REFRESH_MS),
	.MEAS_START(MEAS_START),
	.LOW_CROSSING_FLAG(LOW_CROSSING_FLAG),
	.HIGH_CROSSING_FLAG(HIGH_CROSSING_FLAG)
);

// ---- logic/lsr_cfg.svh ----
// Purpose: named constants of the light sensor upper register bank
// Assumes: included by bare name wherever offsets, bits or timing are needed
// Notes:   definitions only; byte-wide command codes as seen on the two-wire bus
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH

// command codes of the registers in this bank
`define LSR_CMD_LOW       8'h02
`define LSR_CMD_PSM       8'h03
`define LSR_CMD_AMB       8'h04
`define LSR_CMD_WHITE     8'h05
`define LSR_CMD_STAT      8'h06

// bus addresses selected by the address strap
`define LSR_ADDR_HI       7'h48
`define LSR_ADDR_LO       7'h10

// field positions
`define LSR_STAT_LOW_BIT  15
`define LSR_STAT_HIGH_BIT 14
`define LSR_POWER_SAVE_ENABLE_BIT    0
`define LSR_PSM_SEL_HI    2
`define LSR_PSM_SEL_LO    1
`define LSR_PSM_W         3

// reset values
`define LSR_LOW_RST       16'h0000
`define LSR_PSM_RST       3'h0
`define LSR_WORD_RST      16'h0000

// link bit counting and stop hold length in core cycles
`define LSR_LAST_BIT      3'h7
`define LSR_HOLD_CYC      2'h3

// core clock rate and one millisecond in cycles
`define LSR_CLK_MHZ       250
`define LSR_MS_CYC        (`LSR_CLK_MHZ * 1000)

// refresh interval in ms: base per integration code plus extra per mode
`define LSR_IT_100        4'h0
`define LSR_IT_200        4'h1
`define LSR_IT_400        4'h2
`define LSR_IT_800        4'h3
`define LSR_BASE_100      13'h0258
`define LSR_BASE_200      13'h02BC
`define LSR_BASE_400      13'h0384
`define LSR_BASE_800      13'h0514
`define LSR_EXTRA_M1      13'h0000
`define LSR_EXTRA_M2      13'h01F4
`define LSR_EXTRA_M3      13'h05DC
`define LSR_EXTRA_M4      13'h0DAC

`endif

// ---- logic/lsr_pkg.sv ----
// Purpose: types shared by the light sensor register bank
// Assumes: nothing is imported; users write lsr_pkg::name
// Notes:   link phases, write transfer word and read snapshot
package lsr_pkg;

	// phase of the two-wire slave, one per bit group
	typedef enum logic [3:0] {
		LNK_IDLE,
		LNK_ADDR,
		LNK_ADDR_ACK,
		LNK_CMD,
		LNK_CMD_ACK,
		LNK_WDATA,
		LNK_WDATA_ACK,
		LNK_RDATA,
		LNK_RDATA_ACK
	} lsr_link_e;

	// one register write handed from the link to the core
	typedef struct packed {
		logic [7:0]  ptr;
		logic [15:0] data;
	} lsr_wr_s;

	// readable words handed from the core to the link
	typedef struct packed {
		logic [15:0] amb;
		logic [15:0] white;
		logic [1:0]  flags;
	} lsr_snap_s;

endpackage

// ---- logic/lsr_top.sv ----
// Purpose: upper register bank of an ambient light sensor behind a two-wire slave
// Assumes: SCL clocks the link logic; CLK runs the registers; converter and config are on CLK
// Notes:   writes are LSB then MSB; reads return LSB then MSB; open-drain SDA
`timescale 1ns/1ps
`include "lsr_cfg.svh"

module lsr_top #(
	parameter int MS_CYCLES = `LSR_MS_CYC
) (
	// core clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	// two-wire link
	input  wire logic        SCL,
	input  wire logic        SDA_IN,
	output wire logic        SDA_OUT,
	output wire logic        SDA_OE,
	input  wire logic        ADDR_SEL,
	// configuration owned elsewhere
	input  wire logic        ALERT_ENABLE,
	input  wire logic [15:0] HIGH_BOUND,
	input  wire logic [3:0]  INTEGRATION_TIME_CODE,
	// converter results
	input  wire logic        MEAS_VALID,
	input  wire logic [15:0] MEAS_AMBIENT,
	input  wire logic [15:0] MEAS_WHITE,
	// register contents toward the sensor core
	output wire logic [15:0] LOW_BOUND,
	output wire logic        POWER_SAVE_ENABLE,
	output wire logic [1:0]  POWER_SAVE_SELECT,
	output wire logic [12:0] REFRESH_MS,
	output wire logic        MEAS_START,
	output wire logic        LOW_CROSSING_FLAG,
	output wire logic        HIGH_CROSSING_FLAG
);

	localparam int MS_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

	// refresh interval for a power mode and integration code
	function automatic logic [12:0] refresh_ms(input logic [1:0] mode, input logic [3:0] itc);
		logic [12:0] base;
		logic [12:0] extra;
		base  = `LSR_BASE_100;
		extra = `LSR_EXTRA_M1;
		case (itc)
			`LSR_IT_200: base = `LSR_BASE_200;
			`LSR_IT_400: base = `LSR_BASE_400;
			`LSR_IT_800: base = `LSR_BASE_800;
			default:     base = `LSR_BASE_100;
		endcase
		case (mode)
			2'h1:    extra = `LSR_EXTRA_M2;
			2'h2:    extra = `LSR_EXTRA_M3;
			2'h3:    extra = `LSR_EXTRA_M4;
			default: extra = `LSR_EXTRA_M1;
		endcase
		return base + extra;
	endfunction

	// ---------------- link side, clocked by SCL ----------------
	lsr_pkg::lsr_link_e state_reg, state_next;
	logic [2:0]         cnt_reg, cnt_next;
	logic [7:0]         sh_reg, sh_next;
	logic [7:0]         tx_reg, tx_next;
	logic [7:0]         lsb_reg, lsb_next;
	logic               rw_reg, rw_next;
	logic               bidx_reg, bidx_next;
	logic               sda_pos_reg;
	logic               start_seen_reg;
	logic               sda_oe_reg;
	logic [7:0]         ptr_reg;
	lsr_pkg::lsr_wr_s   wr_x_reg;
	logic               wr_tgl_reg;
	logic [1:0]         rdc_flags_reg;
	logic               rdc_tgl_reg;
	logic               pub_s1_reg, pub_s2_reg;
	lsr_pkg::lsr_snap_s shd_reg;
	logic               shd_ack_reg;
	logic               addr_s1_reg, addr_s2_reg;
	logic               hold_reg;
	// core-side publish pair, declared here because the link samples it
	lsr_pkg::lsr_snap_s pub_reg;
	logic               pub_tgl_reg;

	// stop or core reset parks the link; hold is a flop so the gate stays clean
	wire       link_rst_n = RESET_N & ~hold_reg;
	wire [7:0] byte_in    = {sh_reg[6:0], SDA_IN};
	wire       last_bit   = (cnt_reg == `LSR_LAST_BIT);
	wire [6:0] my_addr    = addr_s2_reg ? `LSR_ADDR_HI : `LSR_ADDR_LO;
	wire       in_bit     = ~start_seen_reg;
	wire       cmd_take   = in_bit & (state_reg == lsr_pkg::LNK_CMD) & last_bit;
	wire       wr_fire    = in_bit & (state_reg == lsr_pkg::LNK_WDATA) & last_bit & bidx_reg;
	wire       rd_done    = in_bit & (state_reg == lsr_pkg::LNK_RDATA_ACK) & bidx_reg & (ptr_reg == `LSR_CMD_STAT);
	wire       busy_read  = (state_reg == lsr_pkg::LNK_ADDR_ACK) | (state_reg == lsr_pkg::LNK_RDATA) |
	                        (state_reg == lsr_pkg::LNK_RDATA_ACK);
	wire       shd_take   = (pub_s2_reg != shd_ack_reg) & ~busy_read;

	// word presented for a read; write-only and unmapped codes read as zero
	wire [15:0] stat_word = {shd_reg.flags, 14'h0000};
	wire [15:0] rd_word   = (ptr_reg == `LSR_CMD_AMB)   ? shd_reg.amb :
	                        (ptr_reg == `LSR_CMD_WHITE) ? shd_reg.white :
	                        (ptr_reg == `LSR_CMD_STAT)  ? stat_word : `LSR_WORD_RST;

	// bit sequencing; a start seen on the previous falling edge restarts the address
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg + 3'h1;
		sh_next    = byte_in;
		tx_next    = tx_reg;
		lsb_next   = lsb_reg;
		rw_next    = rw_reg;
		bidx_next  = bidx_reg;
		if (start_seen_reg) begin
			state_next = lsr_pkg::LNK_ADDR;
			cnt_next   = 3'h1;
			sh_next    = {7'h00, SDA_IN};
		end else begin
			case (state_reg)
				lsr_pkg::LNK_IDLE: begin
					cnt_next = 3'h0;
				end
				lsr_pkg::LNK_ADDR: begin
					if (last_bit) begin
						state_next = (byte_in[7:1] == my_addr) ? lsr_pkg::LNK_ADDR_ACK : lsr_pkg::LNK_IDLE;
						rw_next    = byte_in[0];
					end
				end
				lsr_pkg::LNK_ADDR_ACK: begin
					cnt_next   = 3'h0;
					bidx_next  = 1'b0;
					state_next = rw_reg ? lsr_pkg::LNK_RDATA : lsr_pkg::LNK_CMD;
					tx_next    = rd_word[7:0];
				end
				lsr_pkg::LNK_CMD: begin
					if (last_bit) begin
						state_next = lsr_pkg::LNK_CMD_ACK;
					end
				end
				lsr_pkg::LNK_CMD_ACK: begin
					cnt_next   = 3'h0;
					bidx_next  = 1'b0;
					state_next = lsr_pkg::LNK_WDATA;
				end
				lsr_pkg::LNK_WDATA: begin
					if (last_bit) begin
						state_next = lsr_pkg::LNK_WDATA_ACK;
						if (!bidx_reg) begin
							lsb_next = byte_in;
						end
					end
				end
				lsr_pkg::LNK_WDATA_ACK: begin
					cnt_next   = 3'h0;
					bidx_next  = ~bidx_reg;
					state_next = lsr_pkg::LNK_WDATA;
				end
				lsr_pkg::LNK_RDATA: begin
					tx_next = {tx_reg[6:0], 1'b0};
					if (last_bit) begin
						state_next = lsr_pkg::LNK_RDATA_ACK;
					end
				end
				lsr_pkg::LNK_RDATA_ACK: begin
					cnt_next   = 3'h0;
					bidx_next  = ~bidx_reg;
					tx_next    = bidx_reg ? rd_word[7:0] : rd_word[15:8];
					state_next = SDA_IN ? lsr_pkg::LNK_IDLE : lsr_pkg::LNK_RDATA;
				end
				default: begin
					state_next = lsr_pkg::LNK_IDLE;
				end
			endcase
		end
	end

	// sample side of the link; parked state is idle with SDA seen high
	always_ff @(posedge SCL or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state_reg   <= lsr_pkg::LNK_IDLE;
			cnt_reg     <= 3'h0;
			sh_reg      <= 8'h00;
			tx_reg      <= 8'h00;
			lsb_reg     <= 8'h00;
			rw_reg      <= 1'b0;
			bidx_reg    <= 1'b0;
			sda_pos_reg <= 1'b1;
		end else begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			sh_reg      <= sh_next;
			tx_reg      <= tx_next;
			lsb_reg     <= lsb_next;
			rw_reg      <= rw_next;
			bidx_reg    <= bidx_next;
			sda_pos_reg <= SDA_IN;
		end
	end

	// state that must survive a stop: pointer, toggles and the read shadow
	always_ff @(posedge SCL or negedge RESET_N) begin
		if (!RESET_N) begin
			ptr_reg       <= 8'h00;
			wr_x_reg      <= '0;
			wr_tgl_reg    <= 1'b0;
			rdc_flags_reg <= 2'h0;
			rdc_tgl_reg   <= 1'b0;
			pub_s1_reg    <= 1'b0;
			pub_s2_reg    <= 1'b0;
			shd_reg       <= '0;
			shd_ack_reg   <= 1'b0;
			addr_s1_reg   <= 1'b0;
			addr_s2_reg   <= 1'b0;
		end else begin
			pub_s1_reg  <= pub_tgl_reg;
			pub_s2_reg  <= pub_s1_reg;
			addr_s1_reg <= ADDR_SEL;
			addr_s2_reg <= addr_s1_reg;
			if (cmd_take) begin
				ptr_reg <= byte_in;
			end
			if (wr_fire) begin
				wr_x_reg   <= '{ptr: ptr_reg, data: {byte_in, lsb_reg}};
				wr_tgl_reg <= ~wr_tgl_reg;
			end
			if (rd_done) begin
				rdc_flags_reg <= shd_reg.flags;
				rdc_tgl_reg   <= ~rdc_tgl_reg;
			end
			// shadow refresh is held off mid-read so a word never tears
			if (shd_take) begin
				shd_reg     <= pub_reg;
				shd_ack_reg <= pub_s2_reg;
			end
		end
	end

	// drive side: SDA changes only while SCL is low; SDA high at the rising edge and low at the falling edge marks a start
	always_ff @(negedge SCL or negedge link_rst_n) begin
		if (!link_rst_n) begin
			start_seen_reg <= 1'b0;
			sda_oe_reg     <= 1'b0;
		end else begin
			start_seen_reg <= sda_pos_reg & ~SDA_IN;
			case (state_reg)
				lsr_pkg::LNK_ADDR_ACK,
				lsr_pkg::LNK_CMD_ACK,
				lsr_pkg::LNK_WDATA_ACK: sda_oe_reg <= 1'b1;
				lsr_pkg::LNK_RDATA:     sda_oe_reg <= ~tx_reg[7];
				default:                sda_oe_reg <= 1'b0;
			endcase
		end
	end

	assign SDA_OUT = 1'b0;
	assign SDA_OE  = sda_oe_reg;

	// ---------------- core side, clocked by CLK ----------------
	logic               scl_s1_reg, scl_s2_reg;
	logic               sda_s1_reg, sda_s2_reg, sda_s3_reg;
	logic               wr_s1_reg, wr_s2_reg, wr_s3_reg;
	logic               rdt_s1_reg, rdt_s2_reg, rdt_s3_reg;
	logic               ack_s1_reg, ack_s2_reg;
	logic [1:0]         hold_cnt_reg;
	logic [15:0]        low_reg;
	logic [2:0]         psm_reg;
	logic [15:0]        amb_reg, white_reg;
	logic [1:0]         flags_reg, flags_next;
	logic [MS_W-1:0]    ms_cnt_reg;
	logic [12:0]        iv_cnt_reg;
	logic [12:0]        refresh_reg;
	logic               meas_start_reg;

	// event and condition decode
	wire        stop_seen = scl_s2_reg & sda_s2_reg & ~sda_s3_reg;
	wire        wr_take   = wr_s2_reg ^ wr_s3_reg;
	wire        rd_take   = rdt_s2_reg ^ rdt_s3_reg;
	wire        wr_low    = wr_take & (wr_x_reg.ptr == `LSR_CMD_LOW);
	wire        wr_psm    = wr_take & (wr_x_reg.ptr == `LSR_CMD_PSM);
	wire        cmp_on    = MEAS_VALID & ALERT_ENABLE;
	wire        set_low   = cmp_on & (MEAS_AMBIENT < low_reg);
	wire        set_high  = cmp_on & (MEAS_AMBIENT > HIGH_BOUND);
	wire [1:0]  set_vec   = {set_low, set_high};
	wire [1:0]  clr_vec   = rd_take ? rdc_flags_reg : 2'h0;
	wire        power_save_enable    = psm_reg[`LSR_POWER_SAVE_ENABLE_BIT];
	wire        ms_tick   = (ms_cnt_reg == MS_W'(MS_CYCLES - 1));
	wire        iv_end    = (iv_cnt_reg >= (refresh_reg - 13'h0001));
	wire        can_pub   = (ack_s2_reg == pub_tgl_reg);
	wire        pub_diff  = ({amb_reg, white_reg, flags_reg} != pub_reg);

	// a new crossing beats a clear arriving in the same cycle
	assign flags_next = (flags_reg & ~clr_vec) | set_vec;

	// synchronisers for the link pins and the link toggles
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			{scl_s1_reg, scl_s2_reg}             <= 2'h3;
			{sda_s1_reg, sda_s2_reg, sda_s3_reg} <= 3'h7;
			{wr_s1_reg, wr_s2_reg, wr_s3_reg}    <= 3'h0;
			{rdt_s1_reg, rdt_s2_reg, rdt_s3_reg} <= 3'h0;
			{ack_s1_reg, ack_s2_reg}             <= 2'h0;
		end else begin
			{scl_s1_reg, scl_s2_reg}             <= {SCL, scl_s1_reg};
			{sda_s1_reg, sda_s2_reg, sda_s3_reg} <= {SDA_IN, sda_s1_reg, sda_s2_reg};
			{wr_s1_reg, wr_s2_reg, wr_s3_reg}    <= {wr_tgl_reg, wr_s1_reg, wr_s2_reg};
			{rdt_s1_reg, rdt_s2_reg, rdt_s3_reg} <= {rdc_tgl_reg, rdt_s1_reg, rdt_s2_reg};
			{ack_s1_reg, ack_s2_reg}             <= {shd_ack_reg, ack_s1_reg};
		end
	end

	// stop parks the link for a few cycles; the bus is idle then, so no SCL edge is lost
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			hold_cnt_reg <= 2'h0;
			hold_reg     <= 1'b0;
		end else begin
			hold_cnt_reg <= stop_seen ? `LSR_HOLD_CYC : (hold_cnt_reg - {1'b0, hold_reg});
			hold_reg     <= stop_seen | (hold_cnt_reg > 2'h1);
		end
	end

	// writable registers; reserved power bits are simply not stored
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			low_reg <= `LSR_LOW_RST;
			psm_reg <= `LSR_PSM_RST;
		end else begin
			if (wr_low) begin
				low_reg <= wr_x_reg.data;
			end
			if (wr_psm) begin
				psm_reg <= wr_x_reg.data[`LSR_PSM_W-1:0];
			end
		end
	end

	// results, crossing flags and the snapshot offered to the link
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			amb_reg     <= `LSR_WORD_RST;
			white_reg   <= `LSR_WORD_RST;
			flags_reg   <= 2'h0;
			pub_reg     <= '0;
			pub_tgl_reg <= 1'b0;
		end else begin
			flags_reg <= flags_next;
			if (MEAS_VALID) begin
				amb_reg   <= MEAS_AMBIENT;
				white_reg <= MEAS_WHITE;
			end
			// republish only after the link took the last copy
			if (can_pub & pub_diff) begin
				pub_reg     <= '{amb: amb_reg, white: white_reg, flags: flags_reg};
				pub_tgl_reg <= ~pub_tgl_reg;
			end
		end
	end

	// power-saving refresh pacing in whole milliseconds
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ms_cnt_reg     <= '0;
			iv_cnt_reg     <= 13'h0000;
			refresh_reg    <= `LSR_BASE_100;
			meas_start_reg <= 1'b0;
		end else begin
			refresh_reg    <= refresh_ms(psm_reg[`LSR_PSM_SEL_HI:`LSR_PSM_SEL_LO], INTEGRATION_TIME_CODE);
			ms_cnt_reg     <= ms_tick ? '0 : (ms_cnt_reg + 1'b1);
			meas_start_reg <= power_save_enable & ms_tick & iv_end;
			if (!power_save_enable) begin
				iv_cnt_reg <= 13'h0000;
			end else if (ms_tick) begin
				iv_cnt_reg <= iv_end ? 13'h0000 : (iv_cnt_reg + 13'h0001);
			end
		end
	end

	// register-driven outputs
	assign LOW_BOUND          = low_reg;
	assign POWER_SAVE_ENABLE  = power_save_enable;
	assign POWER_SAVE_SELECT  = psm_reg[`LSR_PSM_SEL_HI:`LSR_PSM_SEL_LO];
	assign REFRESH_MS         = refresh_reg;
	assign MEAS_START         = meas_start_reg;
	assign LOW_CROSSING_FLAG  = flags_reg[1];
	assign HIGH_CROSSING_FLAG = flags_reg[0];

endmodule
